// File: testbench.sv
`timescale 1ns/100ps
`define CMP(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error at %0t: got %h want %h", $time, g, e); \
    end \
end
module testbench;
    localparam logic [13:0] MAPPED = 14'h3ce5;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] onchip_wake = 2'h0;
    logic [17:0] ext_pad = 18'h0;
    logic reserved_access_error_en = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, nmi_req, critical_req, machine_check_req;
    logic wakeup_req, nmi_filter_en;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] irq_vec;
    logic [17:0] source_filter_en, source_pullup_en;
    logic [6:0] seen;
    logic [31:0] mdl [14];
    logic [31:0] seed = 32'h0001_52c7;
    int mismatches = 0;
    int n_tests = 0;
    int ks [6] = '{0, 5, 6, 13, 14, 17};

    always #4 core_clk = ~core_clk;

    wu_unit wu_unit_inst (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .onchip_wake, .ext_pad,
        .reserved_access_error_en, .irq_vec, .nmi_req, .critical_req,
        .machine_check_req, .wakeup_req, .nmi_filter_en, .source_filter_en,
        .source_pullup_en);
    wu_far_end wu_far_end_inst (.core_clk, .reset, .irq_vec, .nmi_req,
        .critical_req, .machine_check_req, .wakeup_req, .seen);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic hang();
        mismatches++;
        $display("Error at %0t: bus gave no answer", $time);
        give_verdict();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        logic [1:0] e;
        @(posedge core_clk);
        e = (!MAPPED[a[5:2]] && reserved_access_error_en) ? 2'h2 : 2'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        if (n == 50) hang();
        `CMP(s_axi_bresp, e)
        case (a[5:2])
            4'h0: mdl[0] &= ~(d & 32'hc000_0000);
            4'h2: if (!mdl[2][31]) mdl[2] = d & 32'hf700_0000;
            4'h5: mdl[5] &= ~(d & 32'h3fff_f000);
            4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd: mdl[a[5:2]] = d & 32'h3fff_f000;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n == 50) hang();
    endtask

    task automatic chk();
        logic [31:0] g, f;
        logic [1:0] r;
        logic [6:0] e;
        logic a;
        for (int i = 0; i < 14; i++) begin
            rd(12'(i * 4), g, r);
            f = (i == 5) ? {onchip_wake[0], onchip_wake[1], 30'h0} : 32'h0;
            `CMP(g, mdl[i] | f)
            `CMP(r, (!MAPPED[i] && reserved_access_error_en) ? 2'h2 : 2'h0)
        end
        f = mdl[5] & mdl[6] | {onchip_wake[0], onchip_wake[1], 30'h0};
        a = (mdl[2][26] | mdl[2][25]) & (mdl[0][31] | mdl[0][30]);
        e[6:4] = {|f[15:12], |f[23:16], |f[31:24]};
        e[3:1] = a ? 3'h4 >> mdl[2][30:29] : 3'h0;
        e[0] = |(mdl[5] & mdl[7]) | (|onchip_wake) | a & mdl[2][28];
        `CMP({irq_vec, nmi_req, critical_req, machine_check_req, wakeup_req}, e)
        `CMP(seen, e)
        `CMP(nmi_filter_en, mdl[2][24])
        for (int k = 0; k < 18; k++) begin
            g[1:0] = {mdl[12][29-k], mdl[13][29-k]};
            `CMP({source_filter_en[k], source_pullup_en[k]}, g[1:0])
        end
    endtask

    task automatic pad(input int k, input logic v);
        int b;
        b = 29 - k;
        @(posedge core_clk);
        ext_pad[k] <= v;
        repeat (6) @(posedge core_clk);
        if (v ? mdl[10][b] : mdl[11][b]) mdl[5][b] = 1'h1;
        if (k == 0 && (v ? mdl[2][26] : mdl[2][25])) begin
            mdl[0][30] = mdl[0][31];
            mdl[0][31] = 1'h1;
        end
        chk();
    endtask

    initial begin
        for (int i = 0; i < 14; i++) mdl[i] = 32'h0;
        repeat (20) @(posedge core_clk);
        reset <= 1'h0;
        chk();
        for (int i = 6; i < 14; i++) if (MAPPED[i]) wr(12'(i * 4), rnd());
        wr(12'h004, rnd());
        reserved_access_error_en <= 1'h1;
        wr(12'h020, rnd());
        chk();
        wr(12'h028, 32'h3fff_f000);
        wr(12'h034, 32'h3fff_f000);
        foreach (ks[j]) begin
            pad(ks[j], 1'h1);
            wr(12'h014, 32'h0);
            wr(12'h014, 32'h1 << (29 - ks[j]));
            pad(ks[j], 1'h0);
        end
        // handlers assumed in place before each arming
        for (int d = 0; d < 4; d++) begin
            wr(12'h008, 32'h1600_0000 | (d << 29) | (d[0] << 24));
            pad(0, 1'h1);
            pad(0, 1'h0);
            wr(12'h000, 32'h8000_0000);
            chk();
            wr(12'h000, 32'h4000_0000);
            chk();
        end
        wr(12'h008, 32'h1000_0000);
        pad(0, 1'h1);
        pad(0, 1'h0);
        for (int o = 1; o < 5; o++) begin
            @(posedge core_clk);
            onchip_wake <= o[1:0];
            repeat (6) @(posedge core_clk);
            chk();
        end
        wr(12'h008, 32'h8400_0000);
        wr(12'h008, 32'h0);
        pad(0, 1'h1);
        @(posedge core_clk);
        reset <= 1'h1;
        repeat (20) @(posedge core_clk);
        reset <= 1'h0;
        for (int i = 0; i < 14; i++) mdl[i] = 32'h0;
        chk();
        give_verdict();
    end
endmodule // testbench

// File: wu_edge.sv
`timescale 1ns/100ps
module wu_edge (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [wu_pkg::NUM_EXT-1:0] level,
    output logic [wu_pkg::NUM_EXT-1:0] rise,
    output logic [wu_pkg::NUM_EXT-1:0] fall
);
    wu_pkg::wu_edge_t st_ff;
    wu_pkg::wu_edge_t nxt_st;

    always_comb begin
        nxt_st.prev = level;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rise = level & ~st_ff.prev;
    assign fall = ~level & st_ff.prev;
endmodule // wu_edge

// File: wu_far_end.sv
`timescale 1ns/100ps
module wu_far_end (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] irq_vec,
    input wire logic nmi_req,
    input wire logic critical_req,
    input wire logic machine_check_req,
    input wire logic wakeup_req,
    output logic [6:0] seen
);
    // controller and power logic only latch levels; nothing is acked back
    always @(posedge core_clk) begin
        if (reset) begin
            seen <= 7'h00;
        end else begin
            seen <= {irq_vec, nmi_req, critical_req, machine_check_req,
                wakeup_req};
        end
    end
endmodule // wu_far_end

// File: wu_pkg.sv
package wu_pkg;

    localparam int NUM_EXT = 18;
    localparam int NUM_SRC = 20;
    localparam int ADDR_W = 12;

    // byte offsets of the register bank
    localparam logic [ADDR_W-1:0] OFS_NMI_STAT = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_NMI_CFG = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SRC_FLAG = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_WAKE_EN = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_RISE_EN = 12'h028;
    localparam logic [ADDR_W-1:0] OFS_FALL_EN = 12'h02c;
    localparam logic [ADDR_W-1:0] OFS_FILT_EN = 12'h030;
    localparam logic [ADDR_W-1:0] OFS_PULL_EN = 12'h034;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // source n sits at bit 31 - n; external index k is source k + 2
    localparam int ONCHIP0_BIT = 31;
    localparam int ONCHIP1_BIT = 30;
    localparam int EXT_TOP_BIT = 29;
    localparam int NMI_PAD_IDX = 0;

    // nmi status and config fields
    localparam int NMI_FLAG_BIT = 31;
    localparam int NMI_OVF_BIT = 30;
    localparam int CFG_LOCK_BIT = 31;
    localparam int CFG_DEST_LSB = 29;
    localparam int CFG_WAKE_BIT = 28;
    localparam int CFG_RISE_BIT = 26;
    localparam int CFG_FALL_BIT = 25;
    localparam int CFG_FILT_BIT = 24;

    // external index bounds of the three vectors (vector 0 adds on-chip)
    localparam int GRP0_TOP = 5;
    localparam int GRP1_LOW = 6;
    localparam int GRP1_TOP = 13;
    localparam int GRP2_LOW = 14;

    localparam logic [1:0] DEST_NMI = 2'h0;
    localparam logic [1:0] DEST_CRIT = 2'h1;
    localparam logic [1:0] DEST_MCHK = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef logic [NUM_EXT-1:0] wu_ext_t;

    typedef struct packed {
        logic [NUM_SRC-1:0] stage1;
        logic [NUM_SRC-1:0] stage2;
    } wu_sync_t;

    typedef struct packed {
        wu_ext_t prev;
    } wu_edge_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic nmi_flag;
        logic nmi_ovf;
        logic nmi_lock;
        logic [1:0] nmi_dest;
        logic nmi_wake_en;
        logic nmi_rise_en;
        logic nmi_fall_en;
        logic nmi_filter_en;
        wu_ext_t src_flag;
        wu_ext_t irq_en;
        wu_ext_t wake_en;
        wu_ext_t rise_en;
        wu_ext_t fall_en;
        wu_ext_t filt_en;
        wu_ext_t pull_en;
        logic [2:0] irq_vec;
        logic nmi_req;
        logic crit_req;
        logic mchk_req;
        logic wakeup_req;
    } wu_state_t;

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic wu_ext_t word_to_ext(input logic [31:0] w);
        word_to_ext = '0;
        for (int k = 0; k < NUM_EXT; k++) begin
            word_to_ext[k] = w[EXT_TOP_BIT-k];
        end
    endfunction

    function automatic logic [31:0] ext_to_word(input wu_ext_t v);
        ext_to_word = WORD_ZERO;
        for (int k = 0; k < NUM_EXT; k++) begin
            ext_to_word[EXT_TOP_BIT-k] = v[k];
        end
    endfunction

    function automatic wu_ext_t ext_merge(input wu_ext_t old,
            input logic [31:0] data, input logic [31:0] mask);
        ext_merge = (old & ~word_to_ext(mask)) | word_to_ext(data & mask);
    endfunction

    function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a);
        align = {a[ADDR_W-1:2], WORD_ALIGN};
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (align(a))
            OFS_NMI_STAT, OFS_NMI_CFG, OFS_SRC_FLAG, OFS_IRQ_EN,
            OFS_WAKE_EN, OFS_RISE_EN, OFS_FALL_EN, OFS_FILT_EN,
            OFS_PULL_EN: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

endpackage

// File: wu_sync.sv
`timescale 1ns/100ps
module wu_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [wu_pkg::NUM_SRC-1:0] async_in,
    output logic [wu_pkg::NUM_SRC-1:0] sync_out
);
    wu_pkg::wu_sync_t st_ff;
    wu_pkg::wu_sync_t nxt_st;

    // stage1 feeds stage2 only; metastability settles there
    always_comb begin
        nxt_st.stage1 = async_in;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stage2;
endmodule // wu_sync

// File: wu_unit.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
module wu_unit (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [wu_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wu_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] onchip_wake,
    input wire logic [wu_pkg::NUM_EXT-1:0] ext_pad,
    input wire logic reserved_access_error_en,
    output logic [2:0] irq_vec,
    output logic nmi_req,
    output logic critical_req,
    output logic machine_check_req,
    output logic wakeup_req,
    output logic nmi_filter_en,
    output logic [wu_pkg::NUM_EXT-1:0] source_filter_en,
    output logic [wu_pkg::NUM_EXT-1:0] source_pullup_en
);
    wu_pkg::wu_state_t st_ff;
    wu_pkg::wu_state_t nxt_st;

    logic [wu_pkg::NUM_SRC-1:0] raw_src;
    logic [wu_pkg::NUM_SRC-1:0] sync_src;
    wu_pkg::wu_ext_t ext_lvl;
    wu_pkg::wu_ext_t ext_rise;
    wu_pkg::wu_ext_t ext_fall;
    logic [1:0] onchip_lvl;

    logic wr_go;
    logic [31:0] wmask;
    logic [wu_pkg::ADDR_W-1:0] wa;
    logic [31:0] cfg_new;
    logic [31:0] nmi_clr;
    wu_pkg::wu_ext_t src_clr;
    wu_pkg::wu_ext_t src_evt;
    wu_pkg::wu_ext_t src_irq;
    logic nmi_evt;
    logic nmi_armed;
    logic nmi_pend;

    // source n lands on raw_src[n]
    assign raw_src = {ext_pad, onchip_wake};

    wu_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(raw_src),
        .sync_out(sync_src)
    );

    assign onchip_lvl = sync_src[1:0];
    assign ext_lvl = sync_src[wu_pkg::NUM_SRC-1:2];

    wu_edge u_edge (
        .core_clk(core_clk),
        .reset(reset),
        .level(ext_lvl),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    function automatic logic [31:0] cfg_word(input wu_pkg::wu_state_t s);
        cfg_word = wu_pkg::WORD_ZERO;
        cfg_word[wu_pkg::CFG_LOCK_BIT] = s.nmi_lock;
        cfg_word[wu_pkg::CFG_DEST_LSB+:2] = s.nmi_dest;
        cfg_word[wu_pkg::CFG_WAKE_BIT] = s.nmi_wake_en;
        cfg_word[wu_pkg::CFG_RISE_BIT] = s.nmi_rise_en;
        cfg_word[wu_pkg::CFG_FALL_BIT] = s.nmi_fall_en;
        cfg_word[wu_pkg::CFG_FILT_BIT] = s.nmi_filter_en;
    endfunction

    function automatic logic [31:0] read_word(input wu_pkg::wu_state_t s,
            input logic [1:0] onc, input logic [wu_pkg::ADDR_W-1:0] a);
        read_word = wu_pkg::WORD_ZERO;
        case (wu_pkg::align(a))
            wu_pkg::OFS_NMI_STAT: begin
                read_word[wu_pkg::NMI_FLAG_BIT] = s.nmi_flag;
                read_word[wu_pkg::NMI_OVF_BIT] = s.nmi_ovf;
            end
            wu_pkg::OFS_NMI_CFG: begin
                read_word = cfg_word(s);
            end
            wu_pkg::OFS_SRC_FLAG: begin
                read_word = wu_pkg::ext_to_word(s.src_flag);
                read_word[wu_pkg::ONCHIP0_BIT] = onc[0];
                read_word[wu_pkg::ONCHIP1_BIT] = onc[1];
            end
            wu_pkg::OFS_IRQ_EN: begin
                read_word = wu_pkg::ext_to_word(s.irq_en);
            end
            wu_pkg::OFS_WAKE_EN: begin
                read_word = wu_pkg::ext_to_word(s.wake_en);
            end
            wu_pkg::OFS_RISE_EN: begin
                read_word = wu_pkg::ext_to_word(s.rise_en);
            end
            wu_pkg::OFS_FALL_EN: begin
                read_word = wu_pkg::ext_to_word(s.fall_en);
            end
            wu_pkg::OFS_FILT_EN: begin
                read_word = wu_pkg::ext_to_word(s.filt_en);
            end
            wu_pkg::OFS_PULL_EN: begin
                read_word = wu_pkg::ext_to_word(s.pull_en);
            end
            default: begin
                read_word = wu_pkg::WORD_ZERO;
            end
        endcase
    endfunction

    // error option flags only words outside the map; mapped stay okay
    function automatic logic [1:0] access_resp(input logic err_en,
            input logic [wu_pkg::ADDR_W-1:0] a);
        access_resp = wu_pkg::RESP_OKAY;
        if (err_en && !wu_pkg::is_mapped(a)) begin
            access_resp = wu_pkg::RESP_SLVERR;
        end
    endfunction

    // edge qualification for every pad, nmi on its own enables
    always_comb begin
        src_evt = (ext_rise & st_ff.rise_en) | (ext_fall & st_ff.fall_en);
        nmi_evt = (ext_rise[wu_pkg::NMI_PAD_IDX] & st_ff.nmi_rise_en)
            | (ext_fall[wu_pkg::NMI_PAD_IDX] & st_ff.nmi_fall_en);
        nmi_armed = st_ff.nmi_rise_en | st_ff.nmi_fall_en;
        // overrun alone keeps the request up after the flag is cleared
        nmi_pend = nmi_armed & (st_ff.nmi_flag | st_ff.nmi_ovf);
        src_irq = st_ff.src_flag & st_ff.irq_en;
    end

    // register write decode
    always_comb begin
        wr_go = st_ff.aw_held & st_ff.w_held & ~st_ff.bvalid;
        wmask = wu_pkg::strb_mask(st_ff.wstrb);
        wa = wu_pkg::align(st_ff.waddr);
        cfg_new = (cfg_word(st_ff) & ~wmask) | (st_ff.wdata & wmask);
        nmi_clr = wu_pkg::WORD_ZERO;
        src_clr = '0;
        if (wr_go && wa == wu_pkg::OFS_NMI_STAT) begin
            nmi_clr = st_ff.wdata & wmask;
        end
        if (wr_go && wa == wu_pkg::OFS_SRC_FLAG) begin
            // on-chip bits have no clear path here
            src_clr = wu_pkg::word_to_ext(st_ff.wdata & wmask);
        end
    end

    always_comb begin
        nxt_st = st_ff;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp =
                access_resp(reserved_access_error_en, wa);
        end

        // read channel: one outstanding read, answered next edge
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = read_word(st_ff, onchip_lvl, s_axi_araddr);
            nxt_st.rresp = access_resp(reserved_access_error_en,
                s_axi_araddr);
        end

        // configuration writes; unmapped offsets fall through untouched
        if (wr_go) begin
            case (wa)
                wu_pkg::OFS_NMI_CFG: begin
                    if (!st_ff.nmi_lock) begin
                        nxt_st.nmi_lock = cfg_new[wu_pkg::CFG_LOCK_BIT];
                        nxt_st.nmi_dest = cfg_new[wu_pkg::CFG_DEST_LSB+:2];
                        nxt_st.nmi_wake_en = cfg_new[wu_pkg::CFG_WAKE_BIT];
                        nxt_st.nmi_rise_en = cfg_new[wu_pkg::CFG_RISE_BIT];
                        nxt_st.nmi_fall_en = cfg_new[wu_pkg::CFG_FALL_BIT];
                        nxt_st.nmi_filter_en =
                            cfg_new[wu_pkg::CFG_FILT_BIT];
                    end
                end
                wu_pkg::OFS_IRQ_EN: begin
                    nxt_st.irq_en = wu_pkg::ext_merge(st_ff.irq_en,
                        st_ff.wdata, wmask);
                end
                wu_pkg::OFS_WAKE_EN: begin
                    nxt_st.wake_en = wu_pkg::ext_merge(st_ff.wake_en,
                        st_ff.wdata, wmask);
                end
                wu_pkg::OFS_RISE_EN: begin
                    nxt_st.rise_en = wu_pkg::ext_merge(st_ff.rise_en,
                        st_ff.wdata, wmask);
                end
                wu_pkg::OFS_FALL_EN: begin
                    nxt_st.fall_en = wu_pkg::ext_merge(st_ff.fall_en,
                        st_ff.wdata, wmask);
                end
                wu_pkg::OFS_FILT_EN: begin
                    nxt_st.filt_en = wu_pkg::ext_merge(st_ff.filt_en,
                        st_ff.wdata, wmask);
                end
                wu_pkg::OFS_PULL_EN: begin
                    nxt_st.pull_en = wu_pkg::ext_merge(st_ff.pull_en,
                        st_ff.wdata, wmask);
                end
                default: begin
                    nxt_st.irq_en = st_ff.irq_en;
                end
            endcase
        end

        // flags: a same-cycle event beats the software clear
        nxt_st.src_flag = src_evt | (st_ff.src_flag & ~src_clr);
        nxt_st.nmi_flag = nmi_evt
            | (st_ff.nmi_flag & ~nmi_clr[wu_pkg::NMI_FLAG_BIT]);
        if (nmi_evt) begin
            nxt_st.nmi_ovf = st_ff.nmi_flag;
        end else begin
            nxt_st.nmi_ovf = st_ff.nmi_ovf & ~nmi_clr[wu_pkg::NMI_OVF_BIT];
        end

        // request outputs; no mode gating, pads live in every mode
        nxt_st.irq_vec[0] = (|onchip_lvl)
            | (|src_irq[wu_pkg::GRP0_TOP:0]);
        nxt_st.irq_vec[1] =
            |src_irq[wu_pkg::GRP1_TOP:wu_pkg::GRP1_LOW];
        nxt_st.irq_vec[2] =
            |src_irq[wu_pkg::NUM_EXT-1:wu_pkg::GRP2_LOW];
        // code 11 routes nowhere; the flags still stand for polling
        nxt_st.nmi_req = 1'b0;
        nxt_st.crit_req = 1'b0;
        nxt_st.mchk_req = 1'b0;
        case (st_ff.nmi_dest)
            wu_pkg::DEST_NMI: begin
                nxt_st.nmi_req = nmi_pend;
            end
            wu_pkg::DEST_CRIT: begin
                nxt_st.crit_req = nmi_pend;
            end
            wu_pkg::DEST_MCHK: begin
                nxt_st.mchk_req = nmi_pend;
            end
            default: begin
                nxt_st.nmi_req = 1'b0;
            end
        endcase
        nxt_st.wakeup_req = (|(st_ff.src_flag & st_ff.wake_en))
            | (st_ff.nmi_wake_en & nmi_pend)
            | (|onchip_lvl);

        // ready flags follow the next occupancy, so they stay registered
        nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
        nxt_st.wready = ~nxt_st.w_held & ~nxt_st.bvalid;
        nxt_st.arready = ~nxt_st.rvalid;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output is a field of the registered state
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign irq_vec = st_ff.irq_vec;
    assign nmi_req = st_ff.nmi_req;
    assign critical_req = st_ff.crit_req;
    assign machine_check_req = st_ff.mchk_req;
    assign wakeup_req = st_ff.wakeup_req;
    assign nmi_filter_en = st_ff.nmi_filter_en;
    assign source_filter_en = st_ff.filt_en;
    assign source_pullup_en = st_ff.pull_en;
endmodule // wu_unit

// File: wu_unit_chk.sv
`timescale 1ns/100ps
module wu_unit_chk (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] onchip_wake,
    input wire logic reserved_access_error_en,
    input wire logic [2:0] irq_vec,
    input wire logic nmi_req,
    input wire logic critical_req,
    input wire logic machine_check_req,
    input wire logic wakeup_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    chk_b_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_ar_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    chk_aw_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while busy");
    chk_rresp_okay: assert property (
        s_axi_arvalid && s_axi_arready && !reserved_access_error_en
        |=> s_axi_rresp == 2'h0)
        else $error("error response with option off");
    chk_dest_single: assert property (
        $onehot0({nmi_req, critical_req, machine_check_req}))
        else $error("more than one nmi destination");
    // five cycles cover two sync stages plus the output register
    chk_onchip_irq: assert property (
        (onchip_wake != 2'h0) [*5] |-> irq_vec[0])
        else $error("on-chip source missing on first vector");
    chk_onchip_wake: assert property (
        (onchip_wake != 2'h0) [*5] |-> wakeup_req)
        else $error("on-chip source missing on wakeup");
endmodule // wu_unit_chk
bind wu_unit wu_unit_chk wu_unit_chk_inst (.core_clk, .reset,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .onchip_wake, .reserved_access_error_en,
    .irq_vec, .nmi_req, .critical_req, .machine_check_req, .wakeup_req);
